// File: verilog/vpc_control.sv
/*
 * Emulated PHY basic control register with its effect on the MII port.
 * Reached by a 32-bit memory-map port and by a 16-bit clause 22
 * management register port; loaded whole by the EEPROM loader.
 * Assumes the management frame decoder and loader run on i_clk.
 */
// What this block does
// RL1: Upper and low six bits reserved read-only
// RL2: Soft reset restores defaults, then self-clears
// RL3: Loopback returns MAC frames, blocks fabric
// RL4: Bit 13 forces 10 or 100/200
// RL5: Autoneg enable resets one, overrides forced bits
// RL6: Power down stored, no effect
// RL7: Isolate floats outputs, pulls, ignores inputs
// RL8: MAC mode disregards isolate
// RL9: Isolate never touches management data pin
// RL10: Restart recomputes autoneg results, self-clears
// RL11: Bit 8 forces duplex, resets zero
// RL12: Collision test asserts collision during transmit
// RL13: Use collision test only with loopback; the block asserts col without loopback too
// RL14: Bit 6 reads zero, no effect
// RL15: Loader overwrites whole register after reset
// RL16: Offset 1C0h and management index zero
// RL17: Respond only to strapped PHY address
// RL18: Writes to reserved bits are discarded
// RL19: Self-clearing bits read zero when done
`timescale 1ns/100ps
`default_nettype none
module vpc_control (
   // Clock and reset
   input  wire logic                 i_clk,
   input  wire logic                 i_reset_n,
   // Memory-map port
   input  wire logic                 i_mm_wr,
   input  wire logic                 i_mm_rd,
   input  wire logic [11:0]          i_mm_addr,
   input  wire logic [31:0]          i_mm_wdata,
   output logic      [31:0]          o_mm_rdata,
   // Management register port
   input  wire logic                 i_mdio_wr,
   input  wire logic                 i_mdio_rd,
   input  wire logic [4:0]           i_mdio_phy_addr,
   input  wire logic [4:0]           i_mdio_reg_idx,
   input  wire logic [15:0]          i_mdio_wdata,
   input  wire logic [4:0]           i_strap_phy_addr,
   output logic      [15:0]          o_mdio_rdata,
   output logic                      o_mdio_hit,
   // Management data pin pass-through
   input  wire logic                 i_mdio_out,
   input  wire logic                 i_mdio_drive,
   output logic                      o_mdio_out,
   output logic                      o_mdio_oe_n,
   // EEPROM loader
   input  wire logic                 i_load_valid,
   input  wire logic [15:0]          i_load_data,
   // Port mode
   input  wire vpc_pkg::vpc_mode_e   i_mode,
   // MII from external MAC (asynchronous pins)
   input  wire logic                 i_mii_tx_en,
   input  wire logic                 i_mii_tx_er,
   input  wire logic [3:0]           i_mii_txd,
   // MII toward external MAC
   output logic                      o_mii_rx_dv,
   output logic [3:0]                o_mii_rxd,
   output logic                      o_mii_col,
   output logic                      o_mii_out_oe_n,
   output logic                      o_mii_pull_en,
   // Fabric side
   input  wire logic                 i_fab_rx_dv,
   input  wire logic [3:0]           i_fab_rxd,
   output logic                      o_fab_tx_en,
   output logic                      o_fab_tx_er,
   output logic [3:0]                o_fab_txd,
   // Emulated PHY state
   input  wire logic                 i_an_speed,
   input  wire logic                 i_an_duplex,
   output logic                      o_speed_100,
   output logic                      o_full_duplex,
   output logic                      o_an_update,
   output logic                      o_phy_regs_reset
);
   // ----------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------
   vpc_sync_if mii_s ();

   vpc_sync #(
      .WIDTH (6)
   ) u_sync (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_pins    ({i_mii_tx_en, i_mii_tx_er, i_mii_txd}),
      .o_sync    (mii_s)
   );

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   logic [15:0] ctrl;
   logic [15:0] next_ctrl;
   wire         mm_hit    = (i_mm_addr == vpc_pkg::CTRL_OFFSET);                   // [RL16]
   wire         mdio_sel  = (i_mdio_phy_addr == i_strap_phy_addr) &&
                            (i_mdio_reg_idx == vpc_pkg::CTRL_MII_IDX);             // [RL17]
   wire         mm_write  = i_mm_wr && mm_hit;
   wire         mdio_write = i_mdio_wr && mdio_sel;
   wire [15:0]  wr_data   = mm_write ? i_mm_wdata[15:0] : i_mdio_wdata;
   wire         any_write = mm_write || mdio_write;

   // Writable bits only; reserved and bit 6 stay zero
   function automatic logic [15:0] masked(input logic [15:0] d);
      masked = d & vpc_pkg::CTRL_WR_MASK;                                         // [RL1] [RL14] [RL18]
   endfunction

   // ----------------------------------------------------------------
   // Register update
   // ----------------------------------------------------------------
   always_comb begin
      next_ctrl = ctrl;
      // Self-clearing bits clear after one cycle of action
      next_ctrl[vpc_pkg::BIT_SOFT_RESET] = 1'b0;                                  // [RL2] [RL19]
      next_ctrl[vpc_pkg::BIT_AN_RESTART] = 1'b0;                                  // [RL10] [RL19]
      if (ctrl[vpc_pkg::BIT_SOFT_RESET]) begin
         next_ctrl = vpc_pkg::CTRL_RESET;                                         // [RL2]
      end else if (i_load_valid) begin
         next_ctrl = masked(i_load_data);                                         // [RL15]
      end else if (any_write) begin
         next_ctrl = masked(wr_data);                                             // [RL6] [RL18]
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl <= vpc_pkg::CTRL_RESET;                                             // [RL5] [RL11]
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ----------------------------------------------------------------
   // Read paths
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_mm_rdata   <= 32'h0000_0000;
         o_mdio_rdata <= 16'h0000;
         o_mdio_hit   <= 1'b0;
      end else begin
         o_mm_rdata   <= (i_mm_rd && mm_hit) ? {16'h0000, ctrl} : 32'h0000_0000;  // [RL1]
         o_mdio_rdata <= (i_mdio_rd && mdio_sel) ? ctrl : 16'h0000;               // [RL1]
         o_mdio_hit   <= (i_mdio_rd || i_mdio_wr) && mdio_sel;                    // [RL17]
      end
   end

   // ----------------------------------------------------------------
   // Effects on the port
   // ----------------------------------------------------------------
   wire loopback  = ctrl[vpc_pkg::BIT_LOOPBACK];
   wire an_on     = ctrl[vpc_pkg::BIT_AN_ENABLE];
   wire is_phy    = (i_mode != vpc_pkg::VPC_MODE_MAC);
   wire isolated  = ctrl[vpc_pkg::BIT_ISOLATE] && is_phy;                         // [RL7] [RL8]
   wire tx_en_in  = mii_s.tx_en && !isolated;                                     // [RL7]

   assign o_speed_100   = an_on ? i_an_speed  : ctrl[vpc_pkg::BIT_SPEED_LOW];     // [RL4] [RL5]
   assign o_full_duplex = an_on ? i_an_duplex : ctrl[vpc_pkg::BIT_DUPLEX];        // [RL5] [RL11]
   assign o_an_update      = ctrl[vpc_pkg::BIT_AN_RESTART];                       // [RL10]
   assign o_phy_regs_reset = ctrl[vpc_pkg::BIT_SOFT_RESET];                       // [RL2]
   assign o_mii_out_oe_n   = isolated;                                            // [RL7]
   assign o_mii_pull_en    = !isolated;                                           // [RL7]
   assign o_mdio_out       = i_mdio_out;                                          // [RL9]
   assign o_mdio_oe_n      = !i_mdio_drive;                                       // [RL9]

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_mii_rx_dv <= 1'b0;
         o_mii_rxd   <= 4'h0;
         o_mii_col   <= 1'b0;
         o_fab_tx_en <= 1'b0;
         o_fab_tx_er <= 1'b0;
         o_fab_txd   <= 4'h0;
      end else begin
         o_mii_rx_dv <= loopback ? tx_en_in : i_fab_rx_dv;                        // [RL3]
         o_mii_rxd   <= loopback ? (isolated ? 4'h0 : mii_s.txd) : i_fab_rxd;     // [RL3] [RL7]
         o_mii_col   <= ctrl[vpc_pkg::BIT_COL_TEST] && tx_en_in;                  // [RL12]
         o_fab_tx_en <= tx_en_in && !loopback;                                    // [RL3]
         o_fab_tx_er <= mii_s.tx_er && !isolated && !loopback;
         o_fab_txd   <= (loopback || isolated) ? 4'h0 : mii_s.txd;
      end
   end
endmodule
`default_nettype wire

// File: verilog/vpc_pkg.sv
/*
 * Package for the emulated PHY basic control register: offsets, bit
 * positions, reset values and the port-mode enumeration.
 * Assumes a single 200 MHz device clock domain.
 */
package vpc_pkg;
   // -----------------------------------------------------------------
   // Register addresses
   // -----------------------------------------------------------------
   localparam logic [11:0] CTRL_OFFSET   = 12'h1c0;
   localparam logic [4:0]  CTRL_MII_IDX  = 5'h00;

   // -----------------------------------------------------------------
   // Bit positions
   // -----------------------------------------------------------------
   localparam int BIT_SOFT_RESET   = 15;
   localparam int BIT_LOOPBACK     = 14;
   localparam int BIT_SPEED_LOW    = 13;
   localparam int BIT_AN_ENABLE    = 12;
   localparam int BIT_POWER_DOWN   = 11;
   localparam int BIT_ISOLATE      = 10;
   localparam int BIT_AN_RESTART   = 9;
   localparam int BIT_DUPLEX       = 8;
   localparam int BIT_COL_TEST     = 7;
   localparam int BIT_SPEED_HIGH   = 6;

   // -----------------------------------------------------------------
   // Reset value and writable mask
   // -----------------------------------------------------------------
   localparam logic [15:0] CTRL_RESET    = 16'h1000;
   localparam logic [15:0] CTRL_WR_MASK  = 16'hff80;

   // -----------------------------------------------------------------
   // Port mode
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      VPC_MODE_MII_PHY,
      VPC_MODE_RMII_PHY,
      VPC_MODE_MAC
   } vpc_mode_e;
endpackage

// File: verilog/vpc_sync_if.sv
/*
 * Interface carrying the synchronised MII inputs from the synchroniser
 * to the control block.
 * Assumes both ends share the device clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface vpc_sync_if;
   logic tx_en;
   logic tx_er;
   logic [3:0] txd;
   modport src (output tx_en, output tx_er, output txd);
   modport dst (input tx_en, input tx_er, input txd);
endinterface
`default_nettype wire

// File: verilog/vpc_sync.sv
/*
 * Two-flop synchroniser for MII transmit inputs from the external MAC.
 * Assumes asynchronous pins and the device clock.
 */
`timescale 1ns/100ps
`default_nettype none
module vpc_sync #(
   parameter int WIDTH = 6
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   // Pins
   input  wire logic [WIDTH-1:0] i_pins,
   // Synchronised
   vpc_sync_if.src               o_sync
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] sync;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta <= '0;
         sync <= '0;
      end else begin
         meta <= i_pins;
         sync <= meta;
      end
   end

   assign o_sync.tx_en = sync[5];
   assign o_sync.tx_er = sync[4];
   assign o_sync.txd   = sync[3:0];
endmodule
`default_nettype wire

// File: tb/vpc_mac_model.sv
/* External MAC model driving the MII transmit pins.
   Assumes the device clock; a frame runs while i_send is high. */
`timescale 1ns/100ps
`default_nettype none
module vpc_mac_model (
   // Clock and control
   input  wire logic       i_clk,
   input  wire logic       i_send,
   // MII transmit
   output logic            o_tx_en,
   output logic            o_tx_er,
   output logic [3:0]      o_txd
);
   initial begin
      o_tx_en = 1'b0;
      o_tx_er = 1'b0;
      o_txd   = 4'h0;
   end
   // Counting nibbles in frame, inverted data when idle
   always @(posedge i_clk) begin
      o_tx_en <= i_send;
      o_tx_er <= 1'b0;
      o_txd   <= i_send ? o_txd + 4'h1 : ~o_txd;
   end
endmodule
`default_nettype wire

// File: tb/vpc_control_monitor.sv
/* Checker for the control register ports.
   Bound to vpc_control; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module vpc_control_monitor (
   input wire logic               i_clk, i_reset_n, i_mm_wr, i_mm_rd,
   input wire logic [11:0]        i_mm_addr,
   input wire logic [31:0]        i_mm_wdata, o_mm_rdata,
   input wire logic               i_mdio_wr, i_mdio_rd, o_mdio_hit,
   input wire logic [4:0]         i_mdio_phy_addr, i_mdio_reg_idx, i_strap_phy_addr,
   input wire logic               i_mdio_out, i_mdio_drive, o_mdio_out, o_mdio_oe_n,
   input wire logic               i_load_valid, i_an_speed, i_an_duplex,
   input wire vpc_pkg::vpc_mode_e i_mode,
   input wire logic               o_mii_out_oe_n, o_mii_pull_en, o_speed_100,
   input wire logic               o_full_duplex, o_an_update, o_phy_regs_reset
);
   wire logic wr_hit  = i_mm_wr && i_mm_addr == 12'h1c0 && !i_load_valid && !o_phy_regs_reset;
   wire logic addr_ok = i_mdio_phy_addr == i_strap_phy_addr && i_mdio_reg_idx == 5'h00;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   rd_pad_a: assert property (i_mm_rd && i_mm_addr == 12'h1c0 |=> o_mm_rdata[31:16] == 16'h0 && o_mm_rdata[6:0] == 7'h0)
      else $error("reserved bits read nonzero");
   rd_unmap_a: assert property (i_mm_rd && i_mm_addr != 12'h1c0 |=> o_mm_rdata == 32'h0)
      else $error("unmapped read nonzero");
   mdio_hit_a: assert property (i_mdio_rd |=> o_mdio_hit == $past(addr_ok))
      else $error("management hit wrong");
   soft_reset_a: assert property (wr_hit && i_mm_wdata[15] |=> o_phy_regs_reset ##1 !o_phy_regs_reset)
      else $error("soft reset pulse wrong");
   an_restart_a: assert property (wr_hit && i_mm_wdata[9] && !i_mm_wdata[15] |=> o_an_update ##1 !o_an_update)
      else $error("restart pulse wrong");
   forced_mode_a: assert property (wr_hit && !i_mm_wdata[15] && !i_mm_wdata[12]
      |=> o_speed_100 == $past(i_mm_wdata[13]) && o_full_duplex == $past(i_mm_wdata[8]))
      else $error("forced speed or duplex wrong");
   an_override_a: assert property (wr_hit && !i_mm_wdata[15] && i_mm_wdata[12]
      |=> o_speed_100 == i_an_speed && o_full_duplex == i_an_duplex)
      else $error("autoneg result not used");
   pin_isolate_a: assert property (wr_hit && !i_mm_wdata[15] |=> o_mii_pull_en != o_mii_out_oe_n
      && o_mii_out_oe_n == ($past(i_mm_wdata[10]) && i_mode != vpc_pkg::VPC_MODE_MAC))
      else $error("isolate state wrong");
   mdio_pin_a: assert property (o_mdio_out == i_mdio_out && o_mdio_oe_n == !i_mdio_drive)
      else $error("management pin altered");
endmodule
bind vpc_control vpc_control_monitor u_vpc_control_monitor (.i_clk, .i_reset_n, .i_mm_wr, .i_mm_rd,
   .i_mm_addr, .i_mm_wdata, .o_mm_rdata, .i_mdio_wr, .i_mdio_rd, .o_mdio_hit, .i_mdio_phy_addr,
   .i_mdio_reg_idx, .i_strap_phy_addr, .i_mdio_out, .i_mdio_drive, .o_mdio_out, .o_mdio_oe_n,
   .i_load_valid, .i_an_speed, .i_an_duplex, .i_mode, .o_mii_out_oe_n, .o_mii_pull_en,
   .o_speed_100, .o_full_duplex, .o_an_update, .o_phy_regs_reset);
`default_nettype wire

// File: tb/test_vpc_control.sv
/* Bench for the control register: bus tasks, MAC model, checks.
   Assumes a 200 MHz clock and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module test_vpc_control;
   logic i_clk, i_reset_n, i_mm_wr, i_mm_rd, i_mdio_wr, i_mdio_rd, i_mdio_out, i_mdio_drive, i_load_valid, send;
   logic [11:0] i_mm_addr;
   logic [31:0] i_mm_wdata;
   logic [4:0]  i_mdio_phy_addr, i_mdio_reg_idx, i_strap_phy_addr;
   logic [15:0] i_mdio_wdata, i_load_data;
   vpc_pkg::vpc_mode_e i_mode;
   wire logic [31:0] o_mm_rdata;
   wire logic [15:0] o_mdio_rdata;
   wire logic [3:0]  o_mii_rxd, o_fab_txd, txd;
   wire logic o_mdio_hit, o_mdio_out, o_mdio_oe_n, o_mii_rx_dv, o_mii_col, o_mii_out_oe_n, o_mii_pull_en;
   wire logic o_fab_tx_en, o_fab_tx_er, o_speed_100, o_full_duplex, o_an_update, o_phy_regs_reset, tx_en, tx_er;
   int n_errors, checked, cyc;
   vpc_mac_model u_vpc_mac_model (.i_clk(i_clk), .i_send(send), .o_tx_en(tx_en), .o_tx_er(tx_er), .o_txd(txd));
   vpc_control u_vpc_control (.i_clk, .i_reset_n, .i_mm_wr, .i_mm_rd, .i_mm_addr, .i_mm_wdata, .o_mm_rdata,
      .i_mdio_wr, .i_mdio_rd, .i_mdio_phy_addr, .i_mdio_reg_idx, .i_mdio_wdata, .i_strap_phy_addr,
      .o_mdio_rdata, .o_mdio_hit, .i_mdio_out, .i_mdio_drive, .o_mdio_out, .o_mdio_oe_n, .i_load_valid,
      .i_load_data, .i_mode, .i_mii_tx_en(tx_en), .i_mii_tx_er(tx_er), .i_mii_txd(txd), .o_mii_rx_dv,
      .o_mii_rxd, .o_mii_col, .o_mii_out_oe_n, .o_mii_pull_en, .i_fab_rx_dv(1'b0), .i_fab_rxd(4'h0),
      .o_fab_tx_en, .o_fab_tx_er, .o_fab_txd, .i_an_speed(1'b1), .i_an_duplex(1'b1), .o_speed_100,
      .o_full_duplex, .o_an_update, .o_phy_regs_reset);
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic complete_run();
      if (n_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Memory-map access: write d, or read and expect d
   task automatic mm(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_mm_wr <= w;
      i_mm_rd <= !w;
      i_mm_addr <= a;
      i_mm_wdata <= {16'hffff, d};
      @(posedge i_clk);
      i_mm_wr <= 1'b0;
      i_mm_rd <= 1'b0;
      #1 if (!w) chk("mm_rdata", o_mm_rdata, {16'h0, d});
   endtask
   // Management frame at index zero
   task automatic md(input logic w, input logic [4:0] p, input logic [15:0] d, input logic h);
      @(posedge i_clk);
      i_mdio_wr <= w;
      i_mdio_rd <= !w;
      i_mdio_phy_addr <= p;
      i_mdio_wdata <= d;
      @(posedge i_clk);
      i_mdio_wr <= 1'b0;
      i_mdio_rd <= 1'b0;
      #1 if (!w) chk("mdio_hit", o_mdio_hit, h);
      if (!w && h) chk("mdio_rdata", o_mdio_rdata, d);
   endtask
   // Frame from the MAC; e is rx_dv, fab_tx_en, col mid-frame
   task automatic frame(input logic [2:0] e);
      @(posedge i_clk);
      send <= 1'b1;
      repeat (6) @(posedge i_clk);
      #1 chk("mii_path", {o_mii_rx_dv, o_fab_tx_en, o_mii_col}, e);
      chk("mii_data", {o_mii_rxd, o_fab_txd, o_fab_tx_er}, {e[2] ? txd - 4'h3 : 4'h0, e[1] ? txd - 4'h3 : 4'h0, 1'b0});
      @(posedge i_clk);
      send <= 1'b0;
      repeat (6) @(posedge i_clk);
   endtask
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      {i_mm_wr, i_mm_rd, i_mdio_wr, i_mdio_rd, i_mdio_out, i_mdio_drive, i_load_valid, send} = 8'h0;
      {i_mm_addr, i_mm_wdata, i_mdio_phy_addr, i_mdio_reg_idx, i_mdio_wdata, i_load_data} = 86'h0;
      {n_errors, checked, cyc} = 96'h0;
      i_strap_phy_addr = 5'h05;
      i_mode = vpc_pkg::VPC_MODE_MII_PHY;
      i_reset_n = 1'b0;
      repeat (20) @(posedge i_clk);
      i_reset_n <= 1'b1;
      mm(1'b0, 12'h1c0, 16'h1000);
      md(1'b0, 5'h05, 16'h1000, 1'b1);
      md(1'b0, 5'h06, 16'h0000, 1'b0);
      mm(1'b1, 12'h1c0, 16'h6dff);
      mm(1'b0, 12'h1c0, 16'h6d80);
      chk("isolate", {o_mii_out_oe_n, o_mii_pull_en, o_speed_100, o_full_duplex}, 4'hb);
      frame(3'b000);
      i_mdio_drive <= 1'b1;
      i_mdio_out <= 1'b1;
      i_mode <= vpc_pkg::VPC_MODE_MAC;
      #1 chk("mdio_pin", {o_mdio_out, o_mdio_oe_n, o_mii_out_oe_n}, 3'b100);
      @(posedge i_clk);
      i_mode <= vpc_pkg::VPC_MODE_RMII_PHY;
      mm(1'b1, 12'h1c0, 16'h4080);
      frame(3'b101);
      mm(1'b1, 12'h1c0, 16'h0000);
      frame(3'b010);
      chk("forced", {o_speed_100, o_full_duplex}, 2'b00);
      mm(1'b1, 12'h1c0, 16'h1200);
      mm(1'b0, 12'h1c0, 16'h1000);
      chk("autoneg", {o_speed_100, o_full_duplex}, 2'b11);
      md(1'b1, 5'h05, 16'hc000, 1'b1);
      md(1'b0, 5'h05, 16'h1000, 1'b1);
      mm(1'b1, 12'h1c4, 16'h0100);
      mm(1'b0, 12'h1c4, 16'h0000);
      mm(1'b0, 12'h1c0, 16'h1000);
      mm(1'b1, 12'h1c0, 16'h8900);
      mm(1'b0, 12'h1c0, 16'h1000);
      @(posedge i_clk);
      i_load_valid <= 1'b1;
      i_load_data <= 16'h2140;
      @(posedge i_clk);
      i_load_valid <= 1'b0;
      mm(1'b0, 12'h1c0, 16'h2100);
      complete_run();
   end
endmodule
`default_nettype wire
